// File: core/lae_pkg.sv
// lae_pkg: register map, field positions, reset values and states
package lae_pkg;
  // ------------------------------------------------------------
  // register indices and byte addresses (index times four)
  // ------------------------------------------------------------
  localparam logic [7:0] LAE_IDX_LANE2_CNT = 8'h13;
  localparam logic [7:0] LAE_IDX_LANE3_CNT = 8'h14;
  localparam logic [7:0] LAE_IDX_STATUS = 8'h15;
  localparam logic [7:0] LAE_IDX_CONFIG = 8'h20;
  localparam logic [11:0] LAE_ADDR_LANE2_CNT = {2'h0, LAE_IDX_LANE2_CNT, 2'h0};
  localparam logic [11:0] LAE_ADDR_LANE3_CNT = {2'h0, LAE_IDX_LANE3_CNT, 2'h0};
  localparam logic [11:0] LAE_ADDR_STATUS = {2'h0, LAE_IDX_STATUS, 2'h0};
  localparam logic [11:0] LAE_ADDR_CONFIG = {2'h0, LAE_IDX_CONFIG, 2'h0};
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] LAE_CNT_RESET = 16'hFFFD;
  localparam logic [15:0] LAE_CNT_CLEAR = 16'h0000;
  localparam logic [15:0] LAE_CNT_MAX = 16'hFFFF;
  // ------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------
  localparam int LAE_ST_FIFO_ERR = 15;
  localparam int LAE_ST_SEQ = 11;
  localparam int LAE_ST_LOS = 10;
  localparam int LAE_ST_SYNC = 8;
  localparam int LAE_ST_DEC = 3;
  // ------------------------------------------------------------
  // config field positions (test mode, pattern select, lane select)
  // ------------------------------------------------------------
  localparam int LAE_CF_TEST = 0;
  localparam int LAE_CF_PAT_LO = 4;
  localparam int LAE_CF_LANE_LO = 12;
  localparam logic [15:0] LAE_CF_MASK = 16'h3031;
  // apb slave phases
  typedef enum logic [0:0] {LAE_IDLE, LAE_ACCESS} lae_apb_e;
endpackage

// File: core/lae_lane_if.sv
// lae_lane_if: per-lane error events between top and counter
`timescale 1ns/1ps
interface lae_lane_if;
  logic code_err;
  logic pat_err;
  logic test_mode;
  logic rd_clear;
  logic [15:0] count;
  modport top (output code_err, pat_err, test_mode, rd_clear, input count);
  modport cnt (input code_err, pat_err, test_mode, rd_clear, output count);
endinterface

// File: core/lae_err_counter.sv
// lae_err_counter: one clear-on-read 16-bit lane error counter
`timescale 1ns/1ps
module lae_err_counter
  import lae_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lane events
  lae_lane_if.cnt ln
);
  typedef struct packed {
    logic [15:0] count;
  } lae_cnt_s;
  lae_cnt_s st_r;
  lae_cnt_s st_nxt;
  logic hit;

  // event source depends on mode; saturate so wrap never hides errors
  always_comb
  begin
    st_nxt = st_r;
    hit = ln.test_mode ? ln.pat_err : ln.code_err;
    if (ln.rd_clear)
      st_nxt.count = hit ? 16'h0001 : LAE_CNT_CLEAR;
    else if (hit && st_r.count != LAE_CNT_MAX)
      st_nxt.count = st_r.count + 16'h0001;
  end

  // state register; reset value is the odd startup default
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '{count: LAE_CNT_RESET};
    else
      st_r <= st_nxt;
  end

  assign ln.count = st_r.count;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_clear_on_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    ln.rd_clear && !(ln.test_mode ? ln.pat_err : ln.code_err)
    |=> st_r.count == LAE_CNT_CLEAR)
    else $error("counter not cleared by read");
  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ln.rd_clear && (ln.test_mode ? ln.pat_err : ln.code_err)
    && st_r.count != LAE_CNT_MAX
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("counter missed an error event");
  a_count_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ln.rd_clear && !(ln.test_mode ? ln.pat_err : ln.code_err)
    |=> $stable(st_r.count))
    else $error("counter moved without an event");
endmodule

// File: core/lae_lane_sel.sv
// lae_lane_sel: picks the selected lane's live conditions
`timescale 1ns/1ps
module lae_lane_sel
  import lae_pkg::*;
(
  // lane select
  input wire logic [1:0] sel,
  // per-lane conditions
  input wire logic [3:0] los,
  input wire logic [3:0] sync,
  input wire logic [3:0] dec_err,
  // selected lane
  output logic sel_los,
  output logic sel_sync,
  output logic sel_dec
);
  // plain mux on the config lane select field
  always_comb
  begin
    sel_los = los[sel];
    sel_sync = sync[sel];
    sel_dec = dec_err[sel];
  end
endmodule

// File: core/lae_top.sv
// lae_top: lane error counters and lane alignment status on apb
`timescale 1ns/1ps
module lae_top
  import lae_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lane decoder and checker events, one-cycle pulses
  input wire logic lane2_code_err,
  input wire logic lane3_code_err,
  input wire logic lane2_pat_err,
  input wire logic lane3_pat_err,
  // alignment receiver conditions
  input wire logic align_fifo_err,
  input wire logic align_seq_sending,
  input wire logic [3:0] lane_los,
  input wire logic [3:0] lane_sync,
  input wire logic [3:0] lane_dec_err,
  // configuration seen by the pattern checker
  output logic [1:0] pattern_select,
  output logic test_mode
);
  typedef struct packed {
    lae_apb_e phase;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [15:0] cfg;
    logic fifo_err;
    logic seq;
    logic los;
    logic sync;
    logic dec;
  } lae_top_s;

  lae_top_s st_r;
  lae_top_s st_nxt;
  lae_lane_if ln2 ();
  lae_lane_if ln3 ();
  logic sel_los;
  logic sel_sync;
  logic sel_dec;
  logic rd_hit;
  logic rd_l2;
  logic rd_l3;
  logic rd_st;
  logic [15:0] status_word;

  // ------------------------------------------------------------
  // address decode helper, used for reads and writes
  // ------------------------------------------------------------
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ref_a);
    return a == ref_a;
  endfunction

  // ------------------------------------------------------------
  // lane counters and lane select
  // ------------------------------------------------------------
  // read strobes fire in the setup cycle so data and clear align
  assign rd_hit = psel && !penable && !pwrite && st_r.phase == LAE_IDLE;
  assign rd_l2 = rd_hit && addr_is(paddr, LAE_ADDR_LANE2_CNT);
  assign rd_l3 = rd_hit && addr_is(paddr, LAE_ADDR_LANE3_CNT);
  assign rd_st = rd_hit && addr_is(paddr, LAE_ADDR_STATUS);

  assign ln2.code_err = lane2_code_err;
  assign ln2.pat_err = lane2_pat_err;
  assign ln2.test_mode = st_r.cfg[LAE_CF_TEST];
  assign ln2.rd_clear = rd_l2;
  assign ln3.code_err = lane3_code_err;
  assign ln3.pat_err = lane3_pat_err;
  assign ln3.test_mode = st_r.cfg[LAE_CF_TEST];
  assign ln3.rd_clear = rd_l3;

  lae_err_counter u_cnt2 (
    .pclk(pclk),
    .presetn(presetn),
    .ln(ln2)
  );

  lae_err_counter u_cnt3 (
    .pclk(pclk),
    .presetn(presetn),
    .ln(ln3)
  );

  lae_lane_sel u_sel (
    .sel(st_r.cfg[LAE_CF_LANE_LO +: 2]),
    .los(lane_los),
    .sync(lane_sync),
    .dec_err(lane_dec_err),
    .sel_los(sel_los),
    .sel_sync(sel_sync),
    .sel_dec(sel_dec)
  );

  // ------------------------------------------------------------
  // status word assembly, reserved bits read zero
  // ------------------------------------------------------------
  always_comb
  begin
    status_word = 16'h0000;
    status_word[LAE_ST_FIFO_ERR] = st_r.fifo_err;
    status_word[LAE_ST_SEQ] = st_r.seq;
    status_word[LAE_ST_LOS] = st_r.los;
    status_word[LAE_ST_SYNC] = st_r.sync;
    status_word[LAE_ST_DEC] = st_r.dec;
  end

  // ------------------------------------------------------------
  // next state: apb slave and latched flags
  // ------------------------------------------------------------
  // no wait states: data captured in setup, ready in the first access cycle
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.seq = align_seq_sending;
    // latched flags; a read releases them, new events still win
    if (rd_st)
    begin
      st_nxt.fifo_err = align_fifo_err;
      st_nxt.los = sel_los;
      st_nxt.sync = sel_sync;
      st_nxt.dec = sel_dec;
    end
    else
    begin
      st_nxt.fifo_err = st_r.fifo_err | align_fifo_err;
      st_nxt.los = st_r.los | sel_los;
      st_nxt.sync = st_r.sync & sel_sync;
      st_nxt.dec = st_r.dec | sel_dec;
    end
    unique case (st_r.phase)
      LAE_IDLE:
      begin
        if (psel && !penable)
        begin
          st_nxt.phase = LAE_ACCESS;
          st_nxt.ready = 1'b1;
          st_nxt.rdata = 32'h0000_0000;
          if (addr_is(paddr, LAE_ADDR_LANE2_CNT))
            st_nxt.rdata = {16'h0000, ln2.count};
          else if (addr_is(paddr, LAE_ADDR_LANE3_CNT))
            st_nxt.rdata = {16'h0000, ln3.count};
          else if (addr_is(paddr, LAE_ADDR_STATUS))
            st_nxt.rdata = {16'h0000, status_word};
          else if (addr_is(paddr, LAE_ADDR_CONFIG))
          begin
            st_nxt.rdata = {16'h0000, st_r.cfg};
            if (pwrite)
              st_nxt.cfg = pwdata[15:0] & LAE_CF_MASK;
          end
          else
            st_nxt.err = 1'b1;
          // writes to read-only registers are refused
          if (pwrite && !addr_is(paddr, LAE_ADDR_CONFIG))
            st_nxt.err = 1'b1;
          if (pwrite)
            st_nxt.rdata = 32'h0000_0000;
        end
      end
      LAE_ACCESS:
        st_nxt.phase = LAE_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '{phase: LAE_IDLE, rdata: 32'h0000_0000, ready: 1'b0,
                err: 1'b0, cfg: 16'h0000, fifo_err: 1'b0, seq: 1'b0,
                los: 1'b0, sync: 1'b0, dec: 1'b0};
    else
      st_r <= st_nxt;
  end

  // outputs straight from flops
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign pattern_select = st_r.cfg[LAE_CF_PAT_LO +: 2];
  assign test_mode = st_r.cfg[LAE_CF_TEST];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // named steps shared by the checks; a status read one cycle after
  // an event is legal, so the hold check only spans read-free cycles
  sequence s_fifo_event;
    align_fifo_err;
  endsequence
  sequence s_flag_held;
    st_r.fifo_err [*2];
  endsequence
  sequence s_status_read;
    rd_st;
  endsequence
  sequence s_setup_idle;
    psel && !penable && st_r.phase == LAE_IDLE;
  endsequence
  sequence s_cfg_write;
    s_setup_idle ##0 pwrite && addr_is(paddr, LAE_ADDR_CONFIG);
  endsequence

  // latched-high flags: set on the event, kept until a status read
  a_fifo_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_fifo_event ##1 !rd_st |-> s_flag_held)
    else $error("fifo error flag not latched");
  a_fifo_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.fifo_err && !rd_st |=> st_r.fifo_err)
    else $error("fifo error flag dropped without read");
  a_los_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_los |=> st_r.los)
    else $error("loss of signal not latched");
  a_los_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.los && !rd_st |=> st_r.los)
    else $error("loss of signal flag dropped without read");
  a_dec_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel_dec |=> st_r.dec)
    else $error("decode error not latched");
  a_dec_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.dec && !rd_st |=> st_r.dec)
    else $error("decode error flag dropped without read");

  // latched-low sync: any drop pulls it low, only a read lifts it
  a_sync_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sel_sync |=> !st_r.sync)
    else $error("loss of sync not latched");
  a_sync_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st_r.sync && !rd_st |=> !st_r.sync)
    else $error("sync flag released without read");

  // live sequence bit, one register stage behind the input
  a_seq_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 st_r.seq == $past(align_seq_sending))
    else $error("align sequence bit does not follow input");

  // a status read reloads every latched flag from the live condition
  a_read_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_status_read |=> st_r.los == $past(sel_los)
      && st_r.sync == $past(sel_sync) && st_r.dec == $past(sel_dec)
      && st_r.fifo_err == $past(align_fifo_err))
    else $error("status read did not release flags");

  // counters: read returns the old value and clears in the same edge
  a_cnt_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_l2 && !(test_mode ? lane2_pat_err : lane2_code_err)
    |=> ln2.count == LAE_CNT_CLEAR)
    else $error("lane 2 counter not cleared by read");
  a_cnt3_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_l3 && !(test_mode ? lane3_pat_err : lane3_code_err)
    |=> ln3.count == LAE_CNT_CLEAR)
    else $error("lane 3 counter not cleared by read");
  a_cnt_read_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_l2 |=> prdata[15:0] == $past(ln2.count))
    else $error("lane 2 read did not return the count");

  // apb: one-cycle answer pulse, config applied at the setup edge
  a_apb_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup_idle |=> pready)
    else $error("apb answer late");
  a_apb_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("apb ready held too long");
  a_cfg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> pattern_select == $past(pwdata[LAE_CF_PAT_LO +: 2])
      && test_mode == $past(pwdata[LAE_CF_TEST]))
    else $error("config write not applied");
endmodule

// File: tb/lae_host_model.sv
// lae_host_model: alignment master and lane receivers feeding events
`timescale 1ns/1ps
module lae_host_model
(
  // clock
  input wire logic pclk,
  // per-lane error pulses
  output logic lane2_code_err,
  output logic lane3_code_err,
  output logic lane2_pat_err,
  output logic lane3_pat_err,
  // alignment conditions
  output logic align_fifo_err,
  output logic align_seq_sending,
  output logic [3:0] lane_los,
  output logic [3:0] lane_sync,
  output logic [3:0] lane_dec_err
);
  // idle: every lane in sync, no faults, normal traffic
  initial
  begin
    {lane2_code_err, lane3_code_err} = 2'h0;
    {lane2_pat_err, lane3_pat_err} = 2'h0;
    {align_fifo_err, align_seq_sending} = 2'h0;
    lane_los = 4'h0;
    lane_sync = 4'hF;
    lane_dec_err = 4'h0;
  end
  // counted kind on the first n cycles, the other kind as noise;
  // noise is low on the last cycle so the lines end idle
  task automatic errs(input int n2, input int n3, input logic tst);
    for (int i = 0; i < 25; i++)
    begin
      @(posedge pclk);
      lane2_code_err <= tst ? (i % 2 == 1) : (i < n2);
      lane3_code_err <= tst ? (i % 2 == 1) : (i < n3);
      lane2_pat_err <= tst ? (i < n2) : (i % 2 == 1);
      lane3_pat_err <= tst ? (i < n3) : (i % 2 == 1);
    end
  endtask
  // one-cycle fault on chosen lanes, then back to idle
  task automatic fault(input logic f, input logic [3:0] l,
                       input logic [3:0] d, input logic [3:0] drop);
    @(posedge pclk);
    align_fifo_err <= f;
    lane_los <= l;
    lane_dec_err <= d;
    lane_sync <= ~drop;
    @(posedge pclk);
    align_fifo_err <= 1'b0;
    lane_los <= 4'h0;
    lane_dec_err <= 4'h0;
    lane_sync <= 4'hF;
  endtask
  // switch between align sequence and normal traffic
  task automatic set_seq(input logic v);
    @(posedge pclk);
    align_seq_sending <= v;
  endtask
endmodule

// File: tb/tb.sv
// tb: self-checking bench for lane error counters and status flags
`timescale 1ns/1ps
module tb
  import lae_pkg::*;
();
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic l2c, l3c, l2p, l3p, fifo, seq, tmode;
  logic [3:0] los, sync, dec;
  logic [1:0] pat_sel;
  int num_errors = 0;
  int cmp_count = 0;

  lae_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane2_code_err(l2c), .lane3_code_err(l3c), .lane2_pat_err(l2p),
    .lane3_pat_err(l3p), .align_fifo_err(fifo), .align_seq_sending(seq),
    .lane_los(los), .lane_sync(sync), .lane_dec_err(dec),
    .pattern_select(pat_sel), .test_mode(tmode));
  lae_host_model host_u (.pclk(pclk), .lane2_code_err(l2c),
    .lane3_code_err(l3c), .lane2_pat_err(l2p), .lane3_pat_err(l3p),
    .align_fifo_err(fifo), .align_seq_sending(seq), .lane_los(los),
    .lane_sync(sync), .lane_dec_err(dec));

  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // -------------------------------------------------------------
  // expectations
  // -------------------------------------------------------------
  // counters stick at all ones rather than wrap
  function automatic logic [15:0] cnt_exp(input logic [15:0] s,
                                          input int n);
    int v;
    v = s + n;
    return (v > 16'hFFFF) ? 16'hFFFF : v[15:0];
  endfunction
  function automatic logic [15:0] st(input logic f, input logic s,
    input logic l, input logic y, input logic d);
    return {f, 3'h0, s, l, 1'b0, y, 4'h0, d, 3'h0};
  endfunction
  function automatic logic [31:0] cfg(input logic [1:0] k,
    input logic [1:0] p, input logic t);
    return {16'h0, 2'h0, k, 6'h0, p, 3'h0, t};
  endfunction
  // -------------------------------------------------------------
  // bus and compare tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready wait", 1, 0);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] ex,
                    input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, {16'h0, ex}, q);
    chk("read err", 0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("write err", ee, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog: whole run needs well under this
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop;
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [1:0] k;
    int n2;
    int n3;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(65));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // lane 3 runs past the reset value before its first read
    host_u.errs(0, 5, 1'b0);
    rd(LAE_ADDR_LANE2_CNT, LAE_CNT_RESET, "lane2 reset");
    rd(LAE_ADDR_LANE3_CNT, cnt_exp(LAE_CNT_RESET, 5), "lane3 sat");
    rd(LAE_ADDR_LANE2_CNT, 16'h0000, "lane2 clear");
    rd(LAE_ADDR_LANE3_CNT, 16'h0000, "lane3 clear");
    // every pattern in both modes, the other kind as noise
    for (int m = 0; m < 8; m++)
    begin
      k = 2'($urandom_range(3, 0));
      wr(LAE_ADDR_CONFIG, cfg(k, m[2:1], m[0]), 1'b0);
      chk("pattern_select", m[2:1], pat_sel);
      chk("test_mode", m[0], tmode);
      n2 = (m == 1) ? 20 : $urandom_range(20, 0);
      n3 = $urandom_range(20, 0);
      host_u.errs(n2, n3, m[0]);
      rd(LAE_ADDR_LANE2_CNT, cnt_exp(16'h0, n2), "lane2 count");
      rd(LAE_ADDR_LANE3_CNT, cnt_exp(16'h0, n3), "lane3 count");
    end
    // config readback keeps only defined bits; refusals
    wr(LAE_ADDR_CONFIG, 32'hFFFF_FFFF, 1'b0);
    rd(LAE_ADDR_CONFIG, LAE_CF_MASK, "config");
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    wr(LAE_ADDR_LANE2_CNT, 32'h0000_1234, 1'b1);
    rd(LAE_ADDR_LANE2_CNT, 16'h0000, "lane2 ro");
    // status on a random lane; first read drops startup flags
    k = 2'($urandom_range(3, 0));
    wr(LAE_ADDR_CONFIG, cfg(k, 2'h0, 1'b0), 1'b0);
    apb(1'b0, LAE_ADDR_STATUS, 32'h0, q, e);
    chk("status startup", {16'h0, st(0, 0, 0, 0, 0)}, q);
    rd(LAE_ADDR_STATUS, st(0, 0, 0, 1, 0), "status idle");
    host_u.set_seq(1'b1);
    host_u.fault(1'b1, 4'h1 << k, 4'h1 << k, 4'h1 << k);
    repeat (2) @(posedge pclk);
    rd(LAE_ADDR_STATUS, st(1, 1, 1, 0, 1), "status set");
    rd(LAE_ADDR_STATUS, st(0, 1, 0, 1, 0), "status release");
    // faults on the other lanes must not show
    host_u.set_seq(1'b0);
    host_u.fault(1'b0, ~(4'h1 << k), ~(4'h1 << k), ~(4'h1 << k));
    repeat (2) @(posedge pclk);
    rd(LAE_ADDR_STATUS, st(0, 0, 0, 1, 0), "status others");
    rd(LAE_ADDR_LANE2_CNT, 16'h0000, "lane2 apart");
    report_and_stop;
  end
endmodule
